/* File: shared/hms_cfg.svh */
// Register map, field positions and reset values for the homing sequencer
`ifndef HMS_CFG_SVH
`define HMS_CFG_SVH

// Register byte offsets
`define HMS_OFS_CTRL 4'h0
`define HMS_OFS_STAT 4'h4
`define HMS_OFS_HOME 4'h8
`define HMS_OFS_POS 4'hC

// Control fields
`define HMS_CTRL_MTH_LO 0
`define HMS_CTRL_MTH_HI 5
`define HMS_CTRL_START 8
`define HMS_CTRL_CLR 9

// Status fields
`define HMS_STAT_BUSY 0
`define HMS_STAT_DONE 1
`define HMS_STAT_INV 2
`define HMS_STAT_ALM 3

// Method numbers with special handling
`define HMS_M_MAX 6'h23
`define HMS_M_NOIDX_LO 6'h11
`define HMS_M_NOIDX_HI 6'h1E
`define HMS_M_NOIDX_OFS 6'h10
`define HMS_M_IDX_NEG 6'h21
`define HMS_M_IDX_POS 6'h22
`define HMS_M_HERE 6'h23

// Reset values
`define HMS_RST_METHOD 6'h00
`define HMS_RST_HOME 32'h0000_0000

`endif

/* File: shared/hms_pkg.sv */
// Types shared by the homing sequencer modules
`default_nettype none

package hms_pkg;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      HMS_IDLE = 3'b001,
      HMS_FAST = 3'b010,
      HMS_INDEX = 3'b100
   } hms_state_t;

   // How the first direction is picked
   typedef enum logic [1:0] {
      HMS_SD_POS = 2'h0,
      HMS_SD_NEG = 2'h1,
      HMS_SD_POS_IF_OFF = 2'h2,
      HMS_SD_NEG_IF_OFF = 2'h3
   } hms_start_t;

   // Switch input index, also the edge vector bit
   typedef enum logic [1:0] {
      HMS_SIG_HOME = 2'h0,
      HMS_SIG_NLIM = 2'h1,
      HMS_SIG_PLIM = 2'h2
   } hms_sig_t;

   // Reaction to a limit switch during the search
   typedef enum logic [1:0] {
      HMS_LIM_NONE = 2'h0,
      HMS_LIM_ABORT = 2'h1,
      HMS_LIM_REV = 2'h2
   } hms_lim_t;

   // Method descriptor
   typedef struct packed {
      hms_start_t start;
      hms_sig_t sig;
      logic rise;
      logic tdir;
      logic idir;
      logic idx;
      hms_lim_t lim;
   } hms_desc_t;

endpackage : hms_pkg

`default_nettype wire

/* File: shared/hms_evt_if.sv */
// Switch level and edge events between the edge detector and the sequencer
`default_nettype none

interface hms_evt_if;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface : hms_evt_if

`default_nettype wire

/* File: src/hms_edge.sv */
// Edge detector for the home, limit and index inputs
`default_nettype none

module hms_edge (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] sig_in,
   hms_evt_if.src evt
);
   logic [3:0] prev_q;

   ////////////////////////////////////////////////////////////
   // Previous sample, one per input
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               prev_q[gi] <= 1'b0;
            end else begin
               prev_q[gi] <= sig_in[gi];
            end
         end
         // Both edge directions reported
         assign evt.rise[gi] = sig_in[gi] & ~prev_q[gi];
         assign evt.fall[gi] = ~sig_in[gi] & prev_q[gi];
         assign evt.lvl[gi] = sig_in[gi];
      end
   endgenerate

endmodule : hms_edge

`default_nettype wire

/* File: src/hms_top.sv */
// Homing method sequencer with Avalon-MM register access
`default_nettype none
`include "hms_cfg.svh"

// How it works
// - Method 10: start positive, slow at home fall, index positive.
// - Method 11: negative if switch off else positive; fall moving positive, index.
// - Method 12: negative if switch off else positive; rise moving negative, index.
// - Method 13: start negative; switch rise moving positive slows, index positive.
// - Method 14: start negative; fall moving negative slows, index negative.
// - Method 17: like method 1, home at negative limit rise, no index.
// - Method 18: like method 2, home at positive limit rise, no index.
// - Method 19: like method 3, home at switch fall moving negative.
// - Method 20: like method 4, home at switch rise moving positive.
// - Method 21: like method 5, home at switch fall moving positive.
// - Method 22: like method 6, home at switch rise moving negative.
// - Methods 23-26 follow 7-10, home at the switch edge.
// - Methods 27-30 follow 11-14, home at the switch edge.
// - Method 33: search index negative at once, home there.
// - Method 34: search index positive at once, home there.
// - Method 35: no motion, present position becomes home.
// - Methods 3-6 and 19-22 abort with alarm on any limit.
// - Home and both limits are separate inputs; both home edges acted on, limits only by rise and level.
module hms_top
   import hms_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic home_switch_input,
   input wire logic negative_limit_input,
   input wire logic positive_limit_input,
   input wire logic enc_index,
   input wire logic enc_step,
   input wire logic enc_dir_pos,
   output logic mot_run,
   output logic mot_dir_pos,
   output logic mot_fast,
   output logic home_done,
   output logic home_alarm
);
   import hms_pkg::*;

   ////////////////////////////////////////////////////////////
   // Declarations
   hms_evt_if evt ();
   hms_state_t state_q;
   hms_desc_t dsc_q;
   hms_desc_t dsc_d;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [5:0] method_q;
   logic [31:0] home_q;
   logic [31:0] pos_q;
   logic dir_q;
   logic fast_q;
   logic done_q;
   logic inv_q;
   logic alm_q;
   logic wr_take;
   logic go;
   logic clr;
   logic trig;
   logic other;
   logic lim_hit;
   logic hit_fast;
   logic hit_index;
   logic abort_fast;
   logic abort_index;
   logic start_ok;
   logic start_bad;
   logic here;
   logic set_home;
   logic init_dir;

   ////////////////////////////////////////////////////////////
   // Method helpers

   // True for methods that may run
   function automatic logic hms_valid(input logic [5:0] m);
      logic ok;
      ok = (m != 6'h00) && (m <= `HMS_M_MAX);
      ok = ok && (m != 6'h0F) && (m != 6'h10);
      ok = ok && (m != 6'h1F) && (m != 6'h20);
      return ok;
   endfunction : hms_valid

   // Search descriptor for methods 1 to 30
   function automatic hms_desc_t hms_desc(input logic [5:0] m);
      hms_desc_t d;
      logic [5:0] b;
      logic noidx;
      noidx = (m >= `HMS_M_NOIDX_LO) && (m <= `HMS_M_NOIDX_HI);
      b = noidx ? (m - `HMS_M_NOIDX_OFS) : m;
      d = '{HMS_SD_POS, HMS_SIG_HOME, 1'b0, 1'b0, 1'b0, 1'b1, HMS_LIM_REV};
      d.idx = ~noidx;
      case (b)
         6'h01: d = '{HMS_SD_NEG, HMS_SIG_NLIM, 1'b1, 1'b0, 1'b1, ~noidx, HMS_LIM_NONE};
         6'h02: d = '{HMS_SD_POS, HMS_SIG_PLIM, 1'b1, 1'b1, 1'b0, ~noidx, HMS_LIM_NONE};
         6'h03: d = '{HMS_SD_POS_IF_OFF, HMS_SIG_HOME, 1'b0, 1'b0, 1'b0, ~noidx, HMS_LIM_ABORT};
         6'h04: d = '{HMS_SD_POS_IF_OFF, HMS_SIG_HOME, 1'b1, 1'b1, 1'b1, ~noidx, HMS_LIM_ABORT};
         6'h05: d = '{HMS_SD_NEG_IF_OFF, HMS_SIG_HOME, 1'b0, 1'b1, 1'b1, ~noidx, HMS_LIM_ABORT};
         6'h06: d = '{HMS_SD_NEG_IF_OFF, HMS_SIG_HOME, 1'b1, 1'b0, 1'b0, ~noidx, HMS_LIM_ABORT};
         6'h07: d = '{HMS_SD_POS_IF_OFF, HMS_SIG_HOME, 1'b0, 1'b0, 1'b0, ~noidx, HMS_LIM_REV};
         6'h08: d = '{HMS_SD_POS_IF_OFF, HMS_SIG_HOME, 1'b1, 1'b1, 1'b1, ~noidx, HMS_LIM_REV};
         6'h09: d = '{HMS_SD_POS, HMS_SIG_HOME, 1'b1, 1'b0, 1'b0, ~noidx, HMS_LIM_REV};
         6'h0A: d = '{HMS_SD_POS, HMS_SIG_HOME, 1'b0, 1'b1, 1'b1, ~noidx, HMS_LIM_REV};
         6'h0B: d = '{HMS_SD_NEG_IF_OFF, HMS_SIG_HOME, 1'b0, 1'b1, 1'b1, ~noidx, HMS_LIM_REV};
         6'h0C: d = '{HMS_SD_NEG_IF_OFF, HMS_SIG_HOME, 1'b1, 1'b0, 1'b0, ~noidx, HMS_LIM_REV};
         6'h0D: d = '{HMS_SD_NEG, HMS_SIG_HOME, 1'b1, 1'b1, 1'b1, ~noidx, HMS_LIM_REV};
         6'h0E: d = '{HMS_SD_NEG, HMS_SIG_HOME, 1'b0, 1'b0, 1'b0, ~noidx, HMS_LIM_REV};
         default: d.idx = d.idx;
      endcase
      return d;
   endfunction : hms_desc

   ////////////////////////////////////////////////////////////
   // Edge detection on switches and index
   hms_edge u_edge (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .sig_in({enc_index, positive_limit_input, negative_limit_input, home_switch_input}),
      .evt(evt)
   );

   ////////////////////////////////////////////////////////////
   // Avalon-MM slave

   // One wait cycle, then the answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_take = avs_write & ack_q;
   assign avs_readdata = rdata_q;

   // Acknowledge pulses high for one cycle per request
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // Read data captured in the wait cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read & ~ack_q) begin
         unique case (avs_address)
            `HMS_OFS_CTRL: rdata_q <= {26'h0000000, method_q};
            `HMS_OFS_STAT: rdata_q <= {28'h0000000, alm_q, inv_q, done_q, ~state_q[0]};
            `HMS_OFS_HOME: rdata_q <= home_q;
            `HMS_OFS_POS: rdata_q <= pos_q;
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Control decode
   assign go = wr_take & (avs_address == `HMS_OFS_CTRL) & avs_writedata[`HMS_CTRL_START];
   assign clr = wr_take & (avs_address == `HMS_OFS_CTRL) & avs_writedata[`HMS_CTRL_CLR];

   // Method select, held while busy
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         method_q <= `HMS_RST_METHOD;
      end else if (wr_take && avs_address == `HMS_OFS_CTRL && state_q == HMS_IDLE) begin
         method_q <= avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO];
      end
   end

   // Home position value
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         home_q <= `HMS_RST_HOME;
      end else if (wr_take && avs_address == `HMS_OFS_HOME) begin
         home_q <= avs_writedata;
      end
   end

   ////////////////////////////////////////////////////////////
   // Start decode

   // Method taken from the write data of the start write
   assign dsc_d = hms_desc(avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO]);
   assign start_ok = go & (state_q == HMS_IDLE)
      & hms_valid(avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO]);
   assign start_bad = go & (state_q == HMS_IDLE)
      & ~hms_valid(avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO]);
   assign here = start_ok & (avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO] == `HMS_M_HERE);

   // First direction, fixed or from the home switch state at start
   always_comb begin
      unique case (dsc_d.start)
         HMS_SD_POS: init_dir = 1'b1;
         HMS_SD_NEG: init_dir = 1'b0;
         HMS_SD_POS_IF_OFF: init_dir = ~evt.lvl[HMS_SIG_HOME];
         HMS_SD_NEG_IF_OFF: init_dir = evt.lvl[HMS_SIG_HOME];
      endcase
   end

   ////////////////////////////////////////////////////////////
   // Search events

   // Trigger edge of the selected switch in the trigger direction
   assign trig = (dsc_q.rise ? evt.rise[dsc_q.sig] : evt.fall[dsc_q.sig]) & (dir_q == dsc_q.tdir);
   // Any other home switch edge turns the axis toward the trigger side
   assign other = (dsc_q.sig == HMS_SIG_HOME)
      & (evt.rise[HMS_SIG_HOME] | evt.fall[HMS_SIG_HOME]) & ~trig;
   assign lim_hit = evt.lvl[HMS_SIG_NLIM] | evt.lvl[HMS_SIG_PLIM];
   assign abort_fast = (state_q == HMS_FAST) & (dsc_q.lim == HMS_LIM_ABORT) & lim_hit;
   // Index search stops on the limit ahead, or on any limit for abort methods
   assign abort_index = (state_q == HMS_INDEX)
      & ((dsc_q.lim == HMS_LIM_ABORT) ? lim_hit
      : (dir_q ? evt.lvl[HMS_SIG_PLIM] : evt.lvl[HMS_SIG_NLIM]));
   assign hit_fast = (state_q == HMS_FAST) & ~abort_fast & trig & ~dsc_q.idx;
   assign hit_index = (state_q == HMS_INDEX) & ~abort_index & evt.rise[3];
   assign set_home = hit_fast | hit_index | here;

   ////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= HMS_IDLE;
         dsc_q <= '{HMS_SD_POS, HMS_SIG_HOME, 1'b0, 1'b0, 1'b0, 1'b0, HMS_LIM_NONE};
         dir_q <= 1'b1;
         fast_q <= 1'b0;
      end else begin
         unique case (state_q)
            HMS_IDLE: begin
               if (start_ok && !here) begin
                  dsc_q <= dsc_d;
                  if (avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO] == `HMS_M_IDX_NEG) begin
                     state_q <= HMS_INDEX;
                     dir_q <= 1'b0;
                     fast_q <= 1'b0;
                  end else if (avs_writedata[`HMS_CTRL_MTH_HI:`HMS_CTRL_MTH_LO] == `HMS_M_IDX_POS) begin
                     state_q <= HMS_INDEX;
                     dir_q <= 1'b1;
                     fast_q <= 1'b0;
                  end else begin
                     state_q <= HMS_FAST;
                     dir_q <= init_dir;
                     fast_q <= 1'b1;
                  end
               end
            end
            HMS_FAST: begin
               if (abort_fast) begin
                  state_q <= HMS_IDLE;
               end else if (trig && dsc_q.idx) begin
                  state_q <= HMS_INDEX;
                  fast_q <= 1'b0;
                  dir_q <= dsc_q.idir;
               end else if (trig) begin
                  state_q <= HMS_IDLE;
               end else if (other) begin
                  dir_q <= dsc_q.tdir;
               end else if (dsc_q.lim == HMS_LIM_REV && evt.lvl[HMS_SIG_NLIM] && !dir_q) begin
                  dir_q <= 1'b1;
               end else if (dsc_q.lim == HMS_LIM_REV && evt.lvl[HMS_SIG_PLIM] && dir_q) begin
                  dir_q <= 1'b0;
               end
            end
            HMS_INDEX: begin
               if (abort_index || hit_index) begin
                  state_q <= HMS_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////
   // Position counter, loaded with home at the home point
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pos_q <= 32'h0000_0000;
      end else if (set_home) begin
         pos_q <= home_q;
      end else if (enc_step) begin
         pos_q <= enc_dir_pos ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////
   // Sticky status, set wins over clear, an accepted start clears old results

   // Homing complete
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         done_q <= 1'b0;
      end else if (set_home) begin
         done_q <= 1'b1;
      end else if (clr || start_ok) begin
         done_q <= 1'b0;
      end
   end

   // Invalid method setting
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         inv_q <= 1'b0;
      end else if (start_bad) begin
         inv_q <= 1'b1;
      end else if (clr || start_ok) begin
         inv_q <= 1'b0;
      end
   end

   // Limit alarm
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         alm_q <= 1'b0;
      end else if (abort_fast || abort_index) begin
         alm_q <= 1'b1;
      end else if (clr || start_ok) begin
         alm_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////
   // Motion profile and status outputs
   assign mot_run = ~state_q[0];
   assign mot_dir_pos = dir_q;
   assign mot_fast = fast_q & state_q[1];
   assign home_done = done_q;
   assign home_alarm = alm_q;

endmodule : hms_top

`default_nettype wire

/* File: bench/hms_top_chk.sv */
// Port checker for the homing sequencer
`default_nettype none
`include "hms_cfg.svh"

module hms_top_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic negative_limit_input,
   input wire logic positive_limit_input,
   input wire logic enc_index,
   input wire logic mot_run,
   input wire logic mot_dir_pos,
   input wire logic mot_fast,
   input wire logic home_done,
   input wire logic home_alarm
);
   timeunit 1ns;
   timeprecision 1ns;
   logic go;
   logic ok_m;
   logic [5:0] wm;
   logic [5:0] meth_q;
   // Accepted start command and its method
   assign wm = avs_writedata[5:0];
   assign go = avs_write && !avs_waitrequest && avs_address == `HMS_OFS_CTRL
      && avs_writedata[`HMS_CTRL_START] && !mot_run;
   assign ok_m = wm inside {[6'h01:6'h0E], [6'h11:6'h1E], [6'h21:6'h23]};
   // Method of the run in progress
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meth_q <= 6'h00;
      end else if (go) begin
         meth_q <= wm;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("long bus wait");
   a_done_stops: assert property ($rose(home_done) |-> !mot_run && !home_alarm)
      else $error("done while moving");
   a_limit_abort: assert property (mot_run && (negative_limit_input || positive_limit_input)
      && meth_q inside {[6'h03:6'h06], [6'h13:6'h16]} |-> ##[1:4] (home_alarm && !mot_run))
      else $error("no abort at limit");
   a_here_no_motion: assert property (go && wm == `HMS_M_HERE |=> !mot_run && home_done)
      else $error("method 35 moved");
   a_bad_refused: assert property (go && !ok_m |=> (!mot_run && !home_done) [*2])
      else $error("bad method ran");
   a_start_runs: assert property (go && ok_m && wm != `HMS_M_HERE |=> mot_run)
      else $error("start ignored");
   a_start_dir: assert property (go && wm inside {6'h0A, 6'h0D, 6'h0E, 6'h21, 6'h22}
      |=> mot_dir_pos == (meth_q inside {6'h0A, 6'h22}) && mot_fast == (meth_q < 6'h21))
      else $error("wrong start motion");
   a_index_home: assert property (mot_run && !mot_fast && $rose(enc_index)
      && meth_q inside {[6'h0A:6'h0E], 6'h21, 6'h22} |-> ##[1:4] (!mot_run && home_done))
      else $error("index not taken");
   a_done_sticky: assert property (home_done && !(avs_write && avs_address == `HMS_OFS_CTRL) |=> home_done)
      else $error("done dropped");
   c_done: cover property ($rose(home_done));
   c_alarm: cover property ($rose(home_alarm));
   c_refused: cover property (go && !ok_m);
endmodule : hms_top_chk

bind hms_top hms_top_chk u_chk (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_waitrequest, .negative_limit_input, .positive_limit_input, .enc_index, .mot_run, .mot_dir_pos,
   .mot_fast, .home_done, .home_alarm);

`default_nettype wire

/* File: bench/hms_axis_model.sv */
// Far-side model: axis travel, switches and encoder
`default_nettype none

module hms_axis_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic mot_run,
   input wire logic mot_dir_pos,
   input wire logic load,
   input wire logic [7:0] load_pos,
   output logic [7:0] pos_q,
   output logic enc_step,
   output logic enc_dir_pos,
   output logic home_switch_input,
   output logic negative_limit_input,
   output logic positive_limit_input,
   output logic enc_index
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] div_q;
   // Narrow switch band, limits at the ends, index every 16 counts
   assign home_switch_input = pos_q >= 8'h28 && pos_q <= 8'h2F;
   assign negative_limit_input = pos_q <= 8'h02;
   assign positive_limit_input = pos_q >= 8'h62;
   assign enc_index = pos_q[3:0] == 4'h4;
   // One count every eight cycles while commanded to run
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pos_q <= 8'h1E;
         div_q <= 3'h0;
         enc_step <= 1'b0;
         enc_dir_pos <= 1'b1;
      end else begin
         enc_step <= 1'b0;
         if (load) begin
            pos_q <= load_pos;
            div_q <= 3'h0;
         end else if (mot_run) begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7) begin
               pos_q <= mot_dir_pos ? pos_q + 8'h01 : pos_q - 8'h01;
               enc_step <= 1'b1;
               enc_dir_pos <= mot_dir_pos;
            end
         end
      end
   end
endmodule : hms_axis_model

`default_nettype wire

/* File: bench/hms_top_tb_top.sv */
// Self-checking testbench for the homing sequencer
`default_nettype none
`include "hms_cfg.svh"

module hms_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [5:0] m; logic [7:0] p; logic d; logic [7:0] h; logic a;} hms_run_t;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd, hv;
   logic avs_waitrequest, mot_run, mot_dir_pos, mot_fast, home_done, home_alarm;
   logic home_switch_input, negative_limit_input, positive_limit_input, enc_index, enc_step, enc_dir_pos;
   logic load = 1'b0;
   logic [7:0] load_pos = 8'h00;
   logic [7:0] pos_q;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 88812;
   logic [5:0] bad [7] = '{6'h00, 6'h0F, 6'h10, 6'h1F, 6'h20, 6'h24, 6'h3F};
   // Method, start count, first direction, home count, alarm
   hms_run_t runs [22] = '{
      '{6'h0A, 8'h16, 1'b1, 8'h34, 1'b0}, '{6'h0B, 8'h3C, 1'b0, 8'h34, 1'b0},
      '{6'h0B, 8'h2C, 1'b1, 8'h34, 1'b0}, '{6'h0C, 8'h2C, 1'b1, 8'h24, 1'b0},
      '{6'h0E, 8'h3C, 1'b0, 8'h24, 1'b0}, '{6'h11, 8'h1E, 1'b0, 8'h02, 1'b0},
      '{6'h12, 8'h1E, 1'b1, 8'h62, 1'b0}, '{6'h13, 8'h5A, 1'b1, 8'h62, 1'b1},
      '{6'h14, 8'h1E, 1'b1, 8'h28, 1'b0}, '{6'h15, 8'h2C, 1'b1, 8'h30, 1'b0},
      '{6'h16, 8'h2C, 1'b1, 8'h2F, 1'b0}, '{6'h1A, 8'h16, 1'b1, 8'h30, 1'b0},
      '{6'h1B, 8'h2C, 1'b1, 8'h30, 1'b0}, '{6'h1C, 8'h2C, 1'b1, 8'h2F, 1'b0},
      '{6'h1E, 8'h3C, 1'b0, 8'h27, 1'b0}, '{6'h21, 8'h1E, 1'b0, 8'h14, 1'b0},
      '{6'h0D, 8'h16, 1'b0, 8'h34, 1'b0}, '{6'h17, 8'h16, 1'b1, 8'h27, 1'b0},
      '{6'h19, 8'h3C, 1'b1, 8'h2F, 1'b0}, '{6'h03, 8'h2C, 1'b0, 8'h24, 1'b0},
      '{6'h22, 8'h1E, 1'b1, 8'h24, 1'b0}, '{6'h23, 8'h1E, 1'b1, 8'h1E, 1'b0}};

   hms_top u_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .home_switch_input, .negative_limit_input, .positive_limit_input, .enc_index,
      .enc_step, .enc_dir_pos, .mot_run, .mot_dir_pos, .mot_fast, .home_done, .home_alarm);
   hms_axis_model u_axis (.clk_sys, .nrst, .mot_run, .mot_dir_pos, .load, .load_pos, .pos_q, .enc_step,
      .enc_dir_pos, .home_switch_input, .negative_limit_input, .positive_limit_input, .enc_index);

   ////////////////////////////////////////
   // Clock and cycle limit
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // Expected status and start speed
   function automatic logic [31:0] stat_exp(input logic alm);
      return {28'h0, alm, 1'b0, !alm, 1'b0};
   endfunction : stat_exp
   function automatic logic fast_exp(input logic [5:0] m);
      return m != `HMS_M_IDX_NEG && m != `HMS_M_IDX_POS;
   endfunction : fast_exp

   // Comparison with count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One bus transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   // Verdict
   task automatic tally_and_finish();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////
   // Main sequence
   initial begin
      int n;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      bus(1'b0, `HMS_OFS_CTRL, 32'h0);
      chk("ctrl", rd, 32'h0);
      bus(1'b0, `HMS_OFS_STAT, 32'h0);
      chk("stat", rd, 32'h0);
      hv = $random(seed);
      bus(1'b1, `HMS_OFS_HOME, hv);
      bus(1'b1, 4'h2, ~hv);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b0, `HMS_OFS_HOME, 32'h0);
      chk("home", rd, hv);
      bus(1'b1, `HMS_OFS_CTRL, 32'h0000_002A);
      bus(1'b0, `HMS_OFS_CTRL, 32'h0);
      chk("method", rd, 32'h0000_002A);
      foreach (bad[i]) begin
         bus(1'b1, `HMS_OFS_CTRL, 32'h0000_0200);
         bus(1'b1, `HMS_OFS_CTRL, {23'h0, 1'b1, 2'h0, bad[i]});
         chk("refused", mot_run, 1'b0);
         bus(1'b0, `HMS_OFS_STAT, 32'h0);
         chk("invalid", rd, 32'h0000_0004);
      end
      foreach (runs[i]) begin
         load_pos <= runs[i].p;
         load <= 1'b1;
         @(posedge clk_sys);
         load <= 1'b0;
         hv = $random(seed);
         bus(1'b1, `HMS_OFS_HOME, hv);
         bus(1'b1, `HMS_OFS_CTRL, {23'h0, 1'b1, 2'h0, runs[i].m});
         chk("run", mot_run, runs[i].m != `HMS_M_HERE);
         if (runs[i].m != `HMS_M_HERE) begin
            chk("dir", mot_dir_pos, runs[i].d);
            chk("fast", mot_fast, fast_exp(runs[i].m));
            bus(1'b1, `HMS_OFS_CTRL, {23'h0, 1'b1, 2'h0, `HMS_M_HERE});
            bus(1'b0, `HMS_OFS_CTRL, 32'h0);
            chk("held", rd, {26'h0, runs[i].m});
         end
         n = 0;
         while (home_done !== 1'b1 && home_alarm !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            n++;
         end
         if (n == 3000) chk("timeout", 32'h1, 32'h0);
         repeat (20) @(posedge clk_sys);
         chk("alarm", home_alarm, runs[i].a);
         chk("stop", mot_run, 1'b0);
         chk("home at", pos_q, runs[i].h);
         bus(1'b0, `HMS_OFS_STAT, 32'h0);
         chk("status", rd, stat_exp(runs[i].a));
         bus(1'b0, `HMS_OFS_POS, 32'h0);
         if (!runs[i].a) chk("pos", rd, hv);
      end
      tally_and_finish();
   end
endmodule : hms_top_tb_top

`default_nettype wire
